/* File: logic/npe_bus_cycle.sv */
`timescale 1ns/1ps
module npe_bus_cycle (
	input  wire logic                 mclk_in,
	input  wire logic                 rstn_in,
	input  wire logic                 go_in,
	input  npe_pkg::npe_kind_t        kind_in,
	input  wire logic [7:0]           byte_in,
	input  wire logic [7:0]           io_in,
	output npe_pkg::npe_pins_t        pins_out,
	output logic                      busy_out,
	output logic                      done_out,
	output logic [7:0]                rdata_out
);
	npe_pkg::npe_bc_state_t bc_reg;
	npe_pkg::npe_kind_t     kind_reg;

	// one strobe per byte: setup, strobe low, strobe high with data held
	always_ff @(posedge mclk_in)
	begin
		if (!rstn_in)
		begin
			bc_reg    <= npe_pkg::BC_IDLE;
			kind_reg  <= npe_pkg::KIND_CMD;
			pins_out  <= '{cle: 1'b0, ale: 1'b0, we_n: 1'b1, re_n: 1'b1, io_oe: 1'b0, io: 8'h00};
			busy_out  <= 1'b0;
			done_out  <= 1'b0;
			rdata_out <= 8'h00;
		end
		else
		begin
			done_out <= 1'b0;
			case (bc_reg)
				npe_pkg::BC_IDLE:
				begin
					if (go_in)
					begin
						kind_reg       <= kind_in;
						pins_out.cle   <= (kind_in == npe_pkg::KIND_CMD);
						pins_out.ale   <= (kind_in == npe_pkg::KIND_ADDR);
						pins_out.io_oe <= (kind_in != npe_pkg::KIND_RD);
						pins_out.io    <= byte_in;
						busy_out       <= 1'b1;
						bc_reg         <= npe_pkg::BC_SETUP;
					end
				end
				npe_pkg::BC_SETUP:
				begin
					if (kind_reg == npe_pkg::KIND_RD)
						pins_out.re_n <= 1'b0;
					else
						pins_out.we_n <= 1'b0;
					bc_reg <= npe_pkg::BC_LOW;
				end
				npe_pkg::BC_LOW:
				begin
					// read data is valid a full clock after the read strobe fell
					if (kind_reg == npe_pkg::KIND_RD)
						rdata_out <= io_in;
					pins_out.re_n <= 1'b1;
					pins_out.we_n <= 1'b1;
					bc_reg        <= npe_pkg::BC_HIGH;
				end
				npe_pkg::BC_HIGH:
				begin
					pins_out.cle   <= 1'b0;
					pins_out.ale   <= 1'b0;
					pins_out.io_oe <= 1'b0;
					busy_out       <= 1'b0;
					done_out       <= 1'b1;
					bc_reg         <= npe_pkg::BC_IDLE;
				end
				default:
					bc_reg <= npe_pkg::BC_IDLE;
			endcase
		end
	end
endmodule // npe_bus_cycle

/* File: logic/npe_host_ctrl.sv */
`timescale 1ns/1ps
module npe_host_ctrl (
	input  wire logic        mclk_in,
	input  wire logic        rstn_in,
	input  wire logic [4:0]  avs_address_in,
	input  wire logic        avs_read_in,
	input  wire logic        avs_write_in,
	input  wire logic [31:0] avs_writedata_in,
	input  wire logic [3:0]  avs_byteenable_in,
	output logic [31:0]      avs_readdata_out,
	output logic             avs_waitrequest_out,
	output logic             ce_n_out,
	output logic             cle_out,
	output logic             ale_out,
	output logic             we_n_out,
	output logic             read_strobe_n_out,
	output logic             wp_n_out,
	output logic [7:0]       io_out,
	output logic             io_oe_out,
	input  wire logic [7:0]  io_in,
	input  wire logic        rb_in
);
	npe_pkg::npe_state_t state_reg;
	npe_pkg::npe_ctrl_t  ctrl_reg;
	npe_pkg::npe_ctrl_t  wr_ctrl;
	npe_pkg::npe_pins_t  pins;
	npe_pkg::npe_kind_t  cyc_kind;
	logic [31:0] addr_reg;
	logic [31:0] readdata_next;
	logic [31:0] readdata_reg;
	logic [9:0]  len_reg;
	logic [9:0]  cnt_reg;
	logic [1:0]  addr_idx_reg;
	logic [7:0]  data_reg;
	logic [7:0]  rd_byte_reg;
	logic [7:0]  status_reg;
	logic [7:0]  cyc_byte;
	logic [7:0]  cyc_rdata;
	logic [7:0]  ptr_cmd;
	logic [4:0]  mp_page_reg;
	logic [2:0]  erase_cnt_reg;
	logic [3:0]  tmr_load;
	logic        rd_valid_reg;
	logic        mp_prog_reg;
	logic        stat_mp_reg;
	logic        refused_reg;
	logic        waitreq_reg;
	logic        ce_n_reg;
	logic        wp_n_reg;
	logic        cyc_go_reg;
	logic        cyc_busy;
	logic        cyc_done;
	logic        cyc_state;
	logic        tmr_go_reg;
	logic        tmr_busy;
	logic        tmr_done;
	logic        tmr_state;
	logic        is_data;
	logic        data_wr_ok;
	logic        data_rd_ok;
	logic        av_ack;
	logic        ctrl_go;
	logic        ctrl_ok;
	logic        rd_pending;
	logic        is_erase;

	////////////////////////////////////////////////////////////////////////////////
	// pins

	npe_bus_cycle u_cycle (
		.mclk_in   (mclk_in),
		.rstn_in   (rstn_in),
		.go_in     (cyc_go_reg),
		.kind_in   (cyc_kind),
		.byte_in   (cyc_byte),
		.io_in     (io_in),
		.pins_out  (pins),
		.busy_out  (cyc_busy),
		.done_out  (cyc_done),
		.rdata_out (cyc_rdata)
	);

	npe_wait_timer u_timer (
		.mclk_in  (mclk_in),
		.rstn_in  (rstn_in),
		.go_in    (tmr_go_reg),
		.load_in  (tmr_load),
		.busy_out (tmr_busy),
		.done_out (tmr_done)
	);

	assign cle_out             = pins.cle;
	assign ale_out             = pins.ale;
	assign we_n_out            = pins.we_n;
	assign read_strobe_n_out   = pins.re_n;
	assign io_out              = pins.io;
	assign io_oe_out           = pins.io_oe;
	assign ce_n_out            = ce_n_reg;
	assign wp_n_out            = wp_n_reg;
	assign avs_readdata_out    = readdata_reg;
	assign avs_waitrequest_out = waitreq_reg;

	////////////////////////////////////////////////////////////////////////////////
	// byte and strobe selection

	assign is_erase = (ctrl_reg.op == npe_pkg::OP_ERASE);
	assign tmr_load = (state_reg == npe_pkg::ST_WAIT_WB) ? npe_pkg::WB_CYC : npe_pkg::WHR_CYC;

	always_comb
	begin
		case (ctrl_reg.ptr)
			npe_pkg::PTR_SECOND: ptr_cmd = npe_pkg::CMD_PTR_SECOND;
			npe_pkg::PTR_SPARE:  ptr_cmd = npe_pkg::CMD_PTR_SPARE;
			default:             ptr_cmd = npe_pkg::CMD_PTR_FIRST;
		endcase
	end

	function automatic logic [7:0] addr_byte(input logic [1:0] idx, input logic erase, input logic [31:0] a);
		logic [31:0] m;
		m = a;
		if (erase)
			m[npe_pkg::A_PAGE_HI:npe_pkg::A_CYC1_LO] = '0;
		case (idx)
			npe_pkg::ADDR_IDX_FIRST: addr_byte = m[7:0];
			npe_pkg::ADDR_IDX_BLOCK: addr_byte = m[npe_pkg::A_CYC1_LO +: 8];
			npe_pkg::ADDR_IDX_LAST:  addr_byte = {7'h00, m[npe_pkg::A_TOP]};
			default:                 addr_byte = m[npe_pkg::A_CYC2_LO +: 8];
		endcase
	endfunction

	always_comb
	begin
		cyc_kind  = npe_pkg::KIND_CMD;
		cyc_byte  = 8'h00;
		cyc_state = 1'b1;
		tmr_state = 1'b0;
		case (state_reg)
			npe_pkg::ST_PTR:       cyc_byte = ptr_cmd;
			npe_pkg::ST_SETUP:     cyc_byte = is_erase ? npe_pkg::CMD_ERASE_SETUP : npe_pkg::CMD_DATA_IN;
			npe_pkg::ST_ADDR:
			begin
				cyc_kind = npe_pkg::KIND_ADDR;
				cyc_byte = addr_byte(addr_idx_reg, is_erase, addr_reg);
			end
			npe_pkg::ST_DATA_XFER:
			begin
				cyc_kind = npe_pkg::KIND_WR;
				cyc_byte = data_reg;
			end
			npe_pkg::ST_CONFIRM:
			begin
				if (is_erase)
					cyc_byte = npe_pkg::CMD_ERASE_GO;
				else if (ctrl_reg.mp)
					cyc_byte = npe_pkg::CMD_PROG_DUMMY;
				else
					cyc_byte = npe_pkg::CMD_PROG_GO;
			end
			npe_pkg::ST_STAT_CMD:  cyc_byte = stat_mp_reg ? npe_pkg::CMD_STATUS_MP : npe_pkg::CMD_STATUS;
			npe_pkg::ST_STAT_RD:   cyc_kind = npe_pkg::KIND_RD;
			npe_pkg::ST_RD_XFER:   cyc_kind = npe_pkg::KIND_RD;
			npe_pkg::ST_WAIT_WB,
			npe_pkg::ST_STAT_GAP:
			begin
				cyc_state = 1'b0;
				tmr_state = 1'b1;
			end
			default:               cyc_state = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// command legality

	assign wr_ctrl = npe_pkg::npe_ctrl_t'(avs_writedata_in[npe_pkg::CTRL_W-1:0]);

	always_comb
	begin
		ctrl_ok = 1'b0;
		if (state_reg == npe_pkg::ST_IDLE)
		begin
			case (wr_ctrl.op)
				npe_pkg::OP_PROGRAM:
					ctrl_ok = (len_reg != '0) && (len_reg <= npe_pkg::PAGE_BYTES)
						&& (erase_cnt_reg == '0)
						&& !((wr_ctrl.ptr == npe_pkg::PTR_SECOND) && (wr_ctrl.mp || mp_prog_reg))
						&& !(mp_prog_reg && (addr_reg[npe_pkg::A_PAGE_HI:npe_pkg::A_CYC1_LO] != mp_page_reg));
				npe_pkg::OP_ERASE:
					ctrl_ok = !mp_prog_reg && !(wr_ctrl.mp && (erase_cnt_reg >= npe_pkg::MAX_PLANES - 3'h1));
				npe_pkg::OP_STATUS:
					ctrl_ok = 1'b1;
				npe_pkg::OP_READ:
					ctrl_ok = (len_reg != '0) && (len_reg <= npe_pkg::PAGE_BYTES) && !mp_prog_reg
						&& (erase_cnt_reg == '0);
				default:
					ctrl_ok = 1'b0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// avalon slave: answers one cycle after the request is seen, data port stalls

	assign is_data    = (avs_address_in == npe_pkg::REG_DATA);
	assign data_wr_ok = (state_reg == npe_pkg::ST_DATA_WAIT) || (state_reg == npe_pkg::ST_IDLE);
	assign data_rd_ok = ((state_reg == npe_pkg::ST_RD_WAIT) && rd_valid_reg) || (state_reg == npe_pkg::ST_IDLE);
	assign av_ack     = waitreq_reg && ((avs_write_in && (!is_data || data_wr_ok))
		|| (avs_read_in && (!is_data || data_rd_ok)));
	assign ctrl_go    = av_ack && avs_write_in && (avs_address_in == npe_pkg::REG_CTRL) && avs_byteenable_in[0];
	assign rd_pending = waitreq_reg && avs_read_in && is_data;

	always_comb
	begin
		readdata_next = npe_pkg::WORD_ZERO;
		if (avs_address_in == npe_pkg::REG_CTRL)
			readdata_next[npe_pkg::CTRL_W-1:0] = ctrl_reg;
		else if (avs_address_in == npe_pkg::REG_ADDR)
			readdata_next = addr_reg;
		else if (avs_address_in == npe_pkg::REG_LEN)
			readdata_next[npe_pkg::LEN_W-1:0] = len_reg;
		else if (is_data)
			readdata_next[7:0] = (state_reg == npe_pkg::ST_IDLE) ? 8'h00 : rd_byte_reg;
		else if (avs_address_in == npe_pkg::REG_STAT)
		begin
			readdata_next[7:0]                 = status_reg;
			readdata_next[npe_pkg::STAT_BUSY]   = (state_reg != npe_pkg::ST_IDLE);
			readdata_next[npe_pkg::STAT_REFUSE] = refused_reg;
			readdata_next[npe_pkg::STAT_RB]     = rb_in;
			readdata_next[npe_pkg::STAT_MP]     = mp_prog_reg;
			readdata_next[npe_pkg::STAT_ECNT +: 3] = erase_cnt_reg;
		end
	end

	always_ff @(posedge mclk_in)
	begin
		if (!rstn_in)
		begin
			waitreq_reg  <= 1'b1;
			readdata_reg <= npe_pkg::WORD_ZERO;
		end
		else
		begin
			waitreq_reg <= !av_ack;
			if (av_ack && avs_read_in)
				readdata_reg <= readdata_next;
		end
	end

	always_ff @(posedge mclk_in)
	begin
		if (!rstn_in)
		begin
			addr_reg    <= npe_pkg::WORD_ZERO;
			len_reg     <= '0;
			refused_reg <= 1'b0;
		end
		else
		begin
			if (av_ack && avs_write_in && (avs_address_in == npe_pkg::REG_ADDR))
			begin
				for (int i = 0; i < 4; i++)
				begin
					if (avs_byteenable_in[i])
						addr_reg[i*8 +: 8] <= avs_writedata_in[i*8 +: 8];
				end
			end
			if (av_ack && avs_write_in && (avs_address_in == npe_pkg::REG_LEN) && avs_byteenable_in[0])
				len_reg <= avs_writedata_in[npe_pkg::LEN_W-1:0];
			// a new refusal in the clearing cycle wins over the clear
			if ((ctrl_go && !ctrl_ok) || (av_ack && is_data && (state_reg == npe_pkg::ST_IDLE)))
				refused_reg <= 1'b1;
			else if (av_ack && avs_write_in && (avs_address_in == npe_pkg::REG_STAT)
				&& avs_writedata_in[npe_pkg::STAT_REFUSE])
				refused_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// sequencer

	always_ff @(posedge mclk_in)
	begin
		if (!rstn_in)
		begin
			cyc_go_reg <= 1'b0;
			tmr_go_reg <= 1'b0;
		end
		else
		begin
			cyc_go_reg <= cyc_state && !cyc_busy && !cyc_go_reg && !cyc_done;
			tmr_go_reg <= tmr_state && !tmr_busy && !tmr_go_reg && !tmr_done;
		end
	end

	always_ff @(posedge mclk_in)
	begin
		if (!rstn_in)
		begin
			state_reg     <= npe_pkg::ST_IDLE;
			ctrl_reg      <= '0;
			cnt_reg       <= '0;
			addr_idx_reg  <= npe_pkg::ADDR_IDX_FIRST;
			data_reg      <= 8'h00;
			rd_byte_reg   <= 8'h00;
			rd_valid_reg  <= 1'b0;
			status_reg    <= 8'h00;
			mp_prog_reg   <= 1'b0;
			mp_page_reg   <= '0;
			erase_cnt_reg <= '0;
			stat_mp_reg   <= 1'b0;
			ce_n_reg      <= 1'b1;
			wp_n_reg      <= 1'b0;
		end
		else
		begin
			wp_n_reg <= 1'b1;
			case (state_reg)
				npe_pkg::ST_IDLE:
				begin
					if (ctrl_go && ctrl_ok)
					begin
						ctrl_reg <= wr_ctrl;
						cnt_reg  <= len_reg;
						ce_n_reg <= 1'b0;
						if (wr_ctrl.op == npe_pkg::OP_STATUS)
						begin
							stat_mp_reg <= wr_ctrl.mp;
							state_reg   <= npe_pkg::ST_STAT_CMD;
						end
						else if (wr_ctrl.op == npe_pkg::OP_ERASE)
							state_reg <= npe_pkg::ST_SETUP;
						else
							state_reg <= npe_pkg::ST_PTR;
					end
				end
				npe_pkg::ST_PTR:
				begin
					if (cyc_done)
					begin
						addr_idx_reg <= npe_pkg::ADDR_IDX_FIRST;
						state_reg    <= (ctrl_reg.op == npe_pkg::OP_READ) ? npe_pkg::ST_ADDR : npe_pkg::ST_SETUP;
					end
				end
				npe_pkg::ST_SETUP:
				begin
					if (cyc_done)
					begin
						addr_idx_reg <= is_erase ? npe_pkg::ADDR_IDX_BLOCK : npe_pkg::ADDR_IDX_FIRST;
						state_reg    <= npe_pkg::ST_ADDR;
					end
				end
				npe_pkg::ST_ADDR:
				begin
					if (cyc_done && (addr_idx_reg != npe_pkg::ADDR_IDX_LAST))
						addr_idx_reg <= addr_idx_reg + 2'h1;
					else if (cyc_done)
					begin
						if (ctrl_reg.op == npe_pkg::OP_PROGRAM)
							state_reg <= npe_pkg::ST_DATA_WAIT;
						else if (ctrl_reg.op == npe_pkg::OP_READ)
							state_reg <= npe_pkg::ST_WAIT_WB;
						else if (ctrl_reg.mp)
						begin
							// another plane's block follows before the single confirm
							erase_cnt_reg <= erase_cnt_reg + 3'h1;
							ce_n_reg      <= 1'b1;
							state_reg     <= npe_pkg::ST_IDLE;
						end
						else
							state_reg <= npe_pkg::ST_CONFIRM;
					end
				end
				npe_pkg::ST_DATA_WAIT:
				begin
					if (av_ack && avs_write_in && is_data)
					begin
						data_reg  <= avs_writedata_in[7:0];
						state_reg <= npe_pkg::ST_DATA_XFER;
					end
				end
				npe_pkg::ST_DATA_XFER:
				begin
					if (cyc_done)
					begin
						cnt_reg   <= cnt_reg - 10'h001;
						state_reg <= (cnt_reg == 10'h001) ? npe_pkg::ST_CONFIRM : npe_pkg::ST_DATA_WAIT;
					end
				end
				npe_pkg::ST_CONFIRM:
				begin
					if (cyc_done)
					begin
						if (is_erase)
						begin
							stat_mp_reg   <= (erase_cnt_reg != '0);
							erase_cnt_reg <= '0;
						end
						else
						begin
							stat_mp_reg <= ctrl_reg.mp || mp_prog_reg;
							mp_prog_reg <= ctrl_reg.mp;
							mp_page_reg <= addr_reg[npe_pkg::A_PAGE_HI:npe_pkg::A_CYC1_LO];
						end
						state_reg <= npe_pkg::ST_WAIT_WB;
					end
				end
				npe_pkg::ST_WAIT_WB:
				begin
					// busy is not valid on the pin until the write-to-busy time has passed
					if (tmr_done)
						state_reg <= (ctrl_reg.op == npe_pkg::OP_READ) ? npe_pkg::ST_RB_WAIT : npe_pkg::ST_STAT_CMD;
				end
				npe_pkg::ST_STAT_CMD:
				begin
					if (cyc_done)
						state_reg <= npe_pkg::ST_STAT_GAP;
				end
				npe_pkg::ST_STAT_GAP:
				begin
					if (tmr_done)
						state_reg <= npe_pkg::ST_STAT_RD;
				end
				npe_pkg::ST_STAT_RD:
				begin
					if (cyc_done)
					begin
						status_reg <= cyc_rdata;
						// status mode persists, so polling needs no new command
						if ((ctrl_reg.op == npe_pkg::OP_STATUS) || cyc_rdata[npe_pkg::STS_READY])
						begin
							ce_n_reg  <= 1'b1;
							state_reg <= npe_pkg::ST_IDLE;
						end
					end
				end
				npe_pkg::ST_RB_WAIT:
				begin
					if (rb_in)
						state_reg <= npe_pkg::ST_RD_WAIT;
				end
				npe_pkg::ST_RD_WAIT:
				begin
					if (av_ack && avs_read_in && is_data)
					begin
						rd_valid_reg <= 1'b0;
						cnt_reg      <= cnt_reg - 10'h001;
						if (cnt_reg == 10'h001)
						begin
							// one page per read; chip enable drops so no row crosses a block
							ce_n_reg  <= 1'b1;
							state_reg <= npe_pkg::ST_IDLE;
						end
					end
					else if (!rd_valid_reg && rd_pending)
						state_reg <= npe_pkg::ST_RD_XFER;
				end
				npe_pkg::ST_RD_XFER:
				begin
					if (cyc_done)
					begin
						rd_byte_reg  <= cyc_rdata;
						rd_valid_reg <= 1'b1;
						state_reg    <= npe_pkg::ST_RD_WAIT;
					end
				end
				default:
					state_reg <= npe_pkg::ST_IDLE;
			endcase
		end
	end
endmodule // npe_host_ctrl

/* File: logic/npe_pkg.sv */
package npe_pkg;
	// device command bytes
	localparam logic [7:0] CMD_PTR_FIRST   = 8'h00;
	localparam logic [7:0] CMD_PTR_SECOND  = 8'h01;
	localparam logic [7:0] CMD_PTR_SPARE   = 8'h50;
	localparam logic [7:0] CMD_DATA_IN     = 8'h80;
	localparam logic [7:0] CMD_PROG_GO     = 8'h10;
	localparam logic [7:0] CMD_PROG_DUMMY  = 8'h11;
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
	localparam logic [7:0] CMD_ERASE_GO    = 8'hD0;
	localparam logic [7:0] CMD_STATUS      = 8'h70;
	localparam logic [7:0] CMD_STATUS_MP   = 8'h71;

	// device status byte
	localparam int STS_FAIL  = 0;
	localparam int STS_READY = 6;

	// device address layout
	localparam int A_CYC1_LO = 9;
	localparam int A_CYC2_LO = 17;
	localparam int A_TOP     = 25;
	localparam int A_PAGE_HI = 13;
	localparam int A_PAGE_W  = A_PAGE_HI - A_CYC1_LO + 1;
	localparam logic [1:0] ADDR_IDX_FIRST = 2'h0;
	localparam logic [1:0] ADDR_IDX_BLOCK = 2'h1;
	localparam logic [1:0] ADDR_IDX_LAST  = 2'h3;
	localparam logic [9:0] PAGE_BYTES     = 10'h210;
	localparam logic [2:0] MAX_PLANES     = 3'h4;

	// timing, 20 MHz clock
	localparam int CLK_PERIOD_NS = 50;
	localparam int T_WB_NS       = 100;
	localparam int T_WHR_NS      = 60;
	localparam logic [3:0] WB_CYC  = 4'((T_WB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [3:0] WHR_CYC = 4'((T_WHR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// software register map, byte addresses
	localparam logic [4:0] REG_CTRL = 5'h00;
	localparam logic [4:0] REG_ADDR = 5'h04;
	localparam logic [4:0] REG_LEN  = 5'h08;
	localparam logic [4:0] REG_DATA = 5'h0C;
	localparam logic [4:0] REG_STAT = 5'h10;
	localparam int CTRL_W      = 6;
	localparam int LEN_W       = 10;
	localparam int STAT_BUSY   = 8;
	localparam int STAT_REFUSE = 9;
	localparam int STAT_RB     = 10;
	localparam int STAT_MP     = 11;
	localparam int STAT_ECNT   = 12;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

	localparam logic [2:0] OP_PROGRAM = 3'h1;
	localparam logic [2:0] OP_ERASE   = 3'h2;
	localparam logic [2:0] OP_STATUS  = 3'h3;
	localparam logic [2:0] OP_READ    = 3'h4;
	localparam logic [1:0] PTR_FIRST  = 2'h0;
	localparam logic [1:0] PTR_SECOND = 2'h1;
	localparam logic [1:0] PTR_SPARE  = 2'h2;

	typedef struct packed {
		logic       mp;
		logic [1:0] ptr;
		logic [2:0] op;
	} npe_ctrl_t;

	typedef struct packed {
		logic       cle;
		logic       ale;
		logic       we_n;
		logic       re_n;
		logic       io_oe;
		logic [7:0] io;
	} npe_pins_t;

	typedef enum logic [1:0] {KIND_CMD, KIND_ADDR, KIND_WR, KIND_RD} npe_kind_t;

	typedef enum logic [3:0] {
		BC_IDLE  = 4'h1,
		BC_SETUP = 4'h2,
		BC_LOW   = 4'h4,
		BC_HIGH  = 4'h8
	} npe_bc_state_t;

	typedef enum logic [13:0] {
		ST_IDLE      = 14'h0001,
		ST_PTR       = 14'h0002,
		ST_SETUP     = 14'h0004,
		ST_ADDR      = 14'h0008,
		ST_DATA_WAIT = 14'h0010,
		ST_DATA_XFER = 14'h0020,
		ST_CONFIRM   = 14'h0040,
		ST_WAIT_WB   = 14'h0080,
		ST_STAT_CMD  = 14'h0100,
		ST_STAT_GAP  = 14'h0200,
		ST_STAT_RD   = 14'h0400,
		ST_RB_WAIT   = 14'h0800,
		ST_RD_WAIT   = 14'h1000,
		ST_RD_XFER   = 14'h2000
	} npe_state_t;
endpackage

/* File: logic/npe_wait_timer.sv */
`timescale 1ns/1ps
module npe_wait_timer (
	input  wire logic       mclk_in,
	input  wire logic       rstn_in,
	input  wire logic       go_in,
	input  wire logic [3:0] load_in,
	output logic            busy_out,
	output logic            done_out
);
	logic [3:0] cnt_reg;

	always_ff @(posedge mclk_in)
	begin
		if (!rstn_in)
		begin
			cnt_reg  <= 4'h0;
			busy_out <= 1'b0;
			done_out <= 1'b0;
		end
		else
		begin
			done_out <= 1'b0;
			if (go_in && !busy_out)
			begin
				cnt_reg  <= load_in;
				busy_out <= 1'b1;
			end
			else if (busy_out)
			begin
				if (cnt_reg <= 4'h1)
				begin
					busy_out <= 1'b0;
					done_out <= 1'b1;
				end
				else
					cnt_reg <= cnt_reg - 4'h1;
			end
		end
	end
endmodule // npe_wait_timer

/* File: test/npe_flash_model.sv */
`timescale 1ns/1ps
module npe_flash_model (
	input  wire logic       mclk_in,
	input  wire logic       ce_n_in,
	input  wire logic       cle_in,
	input  wire logic       ale_in,
	input  wire logic       we_n_in,
	input  wire logic       read_strobe_n_in,
	input  wire logic       wp_n_in,
	input  wire logic       fail_in,
	input  wire logic [7:0] io_in,
	output logic [7:0]      io_out = 0,
	output logic            rb_out = 1
);
	logic [7:0] cmd_reg = 0, ptr_reg = 0, adr_reg [4];
	logic       fail_reg = 0;
	int         nadr = 0, ndata = 0, nprog = 0, busy = 0;
	////////////////////////////////
	// only 70h/71h pass while busy
	always @(posedge we_n_in)
		if (!ce_n_in && cle_in && (busy == 0 || io_in[7:1] == 7'h38))
		begin
			if (io_in inside {8'h10, 8'h11} && cmd_reg == 8'h80 && ndata > 0)
			begin
				busy = io_in[0] ? 4 : 40;
				nprog++;
			end
			if (io_in == 8'hd0 && cmd_reg == 8'h60)
				busy = 40;
			fail_reg = fail_in;
			cmd_reg = io_in;
			if (io_in inside {8'h00, 8'h01, 8'h50})
				ptr_reg = io_in;
			nadr = 0;
			if (io_in == 8'h80)
				ndata = 0;
		end
		else if (!ce_n_in && ale_in)
		begin
			adr_reg[nadr % 4] = io_in;
			nadr++;
		end
		else if (!ce_n_in && cmd_reg == 8'h80 && ndata < 528)
			ndata++;
	always @(posedge mclk_in)
	begin
		if (busy > 0)
			busy--;
		rb_out <= (busy == 0);
	end
	// released bus shows the inverse so a stale value never passes
	// a page read after 00h returns the second address byte, so the bench can tell where it read from
	always @(negedge read_strobe_n_in)
		if (cmd_reg[7:1] == 7'h38)
			io_out = {wp_n_in, busy == 0, 1'b0, {5{fail_reg}}};
		else
			io_out = (cmd_reg == 8'h00) ? adr_reg[1] : ~io_out;
	always @(posedge read_strobe_n_in)
		io_out = ~io_out;
endmodule // npe_flash_model

/* File: test/npe_host_ctrl_properties.sv */
`timescale 1ns/1ps
module npe_host_ctrl_properties (
	input wire logic       mclk_in,
	input wire logic       rstn_in,
	input wire logic       avs_waitrequest_out,
	input wire logic       ce_n_out,
	input wire logic       cle_out,
	input wire logic       ale_out,
	input wire logic       we_n_out,
	input wire logic       read_strobe_n_out,
	input wire logic       wp_n_out,
	input wire logic [7:0] io_out,
	input wire logic       io_oe_out,
	input wire logic       rb_in
);
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rstn_in);
	sequence pulse; $fell(we_n_out) ##1 $rose(we_n_out); endsequence
	sequence cmd_busy; cle_out && !we_n_out && !rb_in; endsequence
	////////////////////////////////
	wait_pulse_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out) else $error("wait long");
	strobe_excl_a: assert property (we_n_out || read_strobe_n_out) else $error("two strobes");
	cle_ale_a: assert property (!(cle_out && ale_out)) else $error("cle with ale");
	ce_frame_a: assert property (!(we_n_out && read_strobe_n_out) |-> !ce_n_out) else $error("no ce");
	strobe_one_a: assert property ($fell(we_n_out) |-> pulse) else $error("strobe width");
	drive_hold_a: assert property (!we_n_out |-> io_oe_out && $stable(io_out)) else $error("bus moved");
	busy_cmd_a: assert property (cmd_busy |-> io_out inside {8'h70, 8'h71}) else $error("cmd in busy");
	wp_high_a: assert property ($past(rstn_in) |-> wp_n_out) else $error("wp low");
endmodule // npe_host_ctrl_properties
bind npe_host_ctrl npe_host_ctrl_properties chk_i (.mclk_in, .rstn_in, .avs_waitrequest_out, .ce_n_out, .cle_out,
	.ale_out, .we_n_out, .read_strobe_n_out, .wp_n_out, .io_out, .io_oe_out, .rb_in);

/* File: test/testbench.sv */
`timescale 1ns/1ps
module testbench;
	logic        mclk_in = 0, rstn_in = 0, rd = 0, wr = 0, fail = 0;
	logic        wreq, ce_n, cle, ale, we_n, rstb_n, wp_n, oe, rb;
	logic [4:0]  adr = 0;
	logic [7:0]  dout, din;
	logic [31:0] wdat = 0, rdat, q, a;
	integer      error_cnt = 0, samples_checked = 0, seed = 32'h5a17_88eb, i, n, len;
	always #25 mclk_in = ~mclk_in;
	npe_host_ctrl npe_host_ctrl_i (.mclk_in, .rstn_in, .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
		.avs_writedata_in(wdat), .avs_byteenable_in(4'hf), .avs_readdata_out(rdat), .avs_waitrequest_out(wreq),
		.ce_n_out(ce_n), .cle_out(cle), .ale_out(ale), .we_n_out(we_n), .read_strobe_n_out(rstb_n),
		.wp_n_out(wp_n), .io_out(dout), .io_oe_out(oe), .io_in(din), .rb_in(rb));
	npe_flash_model npe_flash_model_i (.mclk_in, .ce_n_in(ce_n), .cle_in(cle), .ale_in(ale), .we_n_in(we_n),
		.read_strobe_n_in(rstb_n), .wp_n_in(wp_n), .fail_in(fail), .io_in(dout), .io_out(din), .rb_out(rb));
	////////////////////////////////
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [4:0] ad, input logic [31:0] d);
		rd <= !w;
		wr <= w;
		adr <= ad;
		wdat <= d;
		do
			@(posedge mclk_in);
		while (wreq !== 1'b0);
		q = rdat;
		rd <= 0;
		wr <= 0;
		@(posedge mclk_in);
	endtask
	task automatic idle_wait;
		do
			bus(0, npe_pkg::REG_STAT, 0);
		while (q[npe_pkg::STAT_BUSY] !== 1'b0);
	endtask
	function automatic logic [31:0] exp_stat(input logic f);
		return 32'h0000_04c0 | (f ? 32'h0000_001f : 32'h0000_0000);
	endfunction
	task automatic results;
		if (error_cnt == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial
	begin
		repeat (40000) @(posedge mclk_in);
		error_cnt++;
		results();
	end
	initial
	begin
		repeat (2) @(posedge mclk_in);
		rstn_in <= 1;
		repeat (2) @(posedge mclk_in);
		check({ce_n, wp_n}, 2'b11);
		for (i = 0; i < 2; i++)
		begin
			fail <= i[0];
			len = i ? 528 : 1 + ($unsigned($random(seed)) % 4);
			bus(1, npe_pkg::REG_ADDR, $random(seed));
			bus(1, npe_pkg::REG_LEN, len);
			bus(1, npe_pkg::REG_CTRL, 32'(npe_pkg::OP_PROGRAM) | (i << 3));
			for (n = 0; n < len; n++)
				bus(1, npe_pkg::REG_DATA, $random(seed) & 32'h0000_00ff);
			idle_wait();
			check(q, exp_stat(i[0]));
			check(npe_flash_model_i.ndata, len);
			check(npe_flash_model_i.nprog, i + 1);
			check(npe_flash_model_i.ptr_reg, i ? 8'h01 : 8'h00);
		end
		for (i = 0; i < 2; i++)
		begin
			bus(1, npe_pkg::REG_LEN, i ? 529 : 0);
			bus(1, npe_pkg::REG_CTRL, 32'(npe_pkg::OP_PROGRAM));
			bus(0, npe_pkg::REG_STAT, 0);
			check(q[npe_pkg::STAT_REFUSE], 1);
			check(npe_flash_model_i.nprog, 2);
			bus(1, npe_pkg::REG_STAT, 32'h0000_0200);
		end
		fail <= 0;
		a = ($random(seed) & 32'h03ff_ffff) | 32'h0000_3e00;
		bus(1, npe_pkg::REG_ADDR, a);
		bus(1, npe_pkg::REG_CTRL, 32'(npe_pkg::OP_ERASE));
		idle_wait();
		check(q, exp_stat(0));
		check(npe_flash_model_i.adr_reg[0], {a[16:14], 5'h00});
		bus(1, npe_pkg::REG_CTRL, 32'(npe_pkg::OP_STATUS));
		idle_wait();
		check(q, exp_stat(0));
		bus(0, 5'h14, 0);
		check(q, 0);
		bus(1, npe_pkg::REG_CTRL, 32'(npe_pkg::OP_ERASE) | 32'h0000_0020);
		idle_wait();
		check(q[npe_pkg::STAT_ECNT +: 3], 1);
		bus(1, npe_pkg::REG_CTRL, 32'(npe_pkg::OP_ERASE));
		idle_wait();
		check(q, exp_stat(0));
		check(npe_flash_model_i.cmd_reg, 8'h71);
		bus(1, npe_pkg::REG_LEN, 2);
		bus(1, npe_pkg::REG_CTRL, 32'(npe_pkg::OP_READ));
		for (n = 0; n < 2; n++)
		begin
			bus(0, npe_pkg::REG_DATA, 0);
			check(q, {24'h00_0000, a[16:9]});
		end
		check(ce_n, 1);
		results();
	end
endmodule // testbench
